// ### common/ramp_pwm_defs.vh
`ifndef RAMP_PWM_DEFS_VH
`define RAMP_PWM_DEFS_VH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define ADDR_CL_CONFIG_ONE  12'h048
`define ADDR_TARGET_SPEED   12'h080
`define ADDR_RAMP_STATUS    12'h084
`define ADDR_BITS           12
`define CL_CONFIG_RESET     32'h0000_0000
`define CL_CONFIG_MASK      32'hFFFF_FFFF

// ----------------------------------------------------------------
// Field positions in closed_loop_config_one
// ----------------------------------------------------------------
`define ACCEL_MSB           18
`define ACCEL_LSB           14
`define DECEL_SRC_BIT       13
`define DECEL_MSB           12
`define DECEL_LSB           8
`define FSW_MSB             7
`define FSW_LSB             4
`define SURGE_EN_BIT        3
`define DEADBAND_EN_BIT     2
`define VLOOP_DIS_BIT       1
`define PWM_MODE_BIT        0

// ----------------------------------------------------------------
// Clock and switching frequency
// ----------------------------------------------------------------
`define CLK_HZ              25000000
`define FSW_BASE_HZ         10000
`define FSW_STEP_HZ         5000
`define FSW_LAST_CODE       4'hD
`define FSW_FALLBACK_CODE   4'h0
`define FSW_CODES           14
`define PER_BITS            12
`define PWM_PERIOD(n)       (`CLK_HZ / (`FSW_BASE_HZ + (n) * `FSW_STEP_HZ))

// ----------------------------------------------------------------
// Ramp rates in half-hertz per second; speed in half-hertz steps
// ----------------------------------------------------------------
`define RATE_NO_LIMIT_CODE  5'h1F
`define RATE_CYCLES_PER_S   32'd25000000
`define RATE_TABLE_LEN      31
`define SPEED_BITS          24
`define DUTY_BITS           12
`define DUTY_MID            13'h0800
`define RATE_00 18'd1
`define RATE_01 18'd2
`define RATE_02 18'd5
`define RATE_03 18'd10
`define RATE_04 18'd15
`define RATE_05 18'd20
`define RATE_06 18'd40
`define RATE_07 18'd80
`define RATE_08 18'd120
`define RATE_09 18'd160
`define RATE_0A 18'd200
`define RATE_0B 18'd400
`define RATE_0C 18'd600
`define RATE_0D 18'd800
`define RATE_0E 18'd1000
`define RATE_0F 18'd1200
`define RATE_10 18'd1400
`define RATE_11 18'd1600
`define RATE_12 18'd1800
`define RATE_13 18'd2000
`define RATE_14 18'd4000
`define RATE_15 18'd8000
`define RATE_16 18'd12000
`define RATE_17 18'd16000
`define RATE_18 18'd20000
`define RATE_19 18'd40000
`define RATE_1A 18'd60000
`define RATE_1B 18'd80000
`define RATE_1C 18'd100000
`define RATE_1D 18'd120000
`define RATE_1E 18'd140000

`endif

// ### hw/svm_pwm_gen.v
`timescale 1ns/100ps
`default_nettype none
`include "ramp_pwm_defs.vh"

module svm_pwm_gen (
    // Clock and reset
    input  wire                      clk,
    input  wire                      sys_rst,
    input  wire                      ce,
    // Settings
    input  wire [3:0]                freqCode,
    input  wire                      discontinuous,
    // Phase commands, mid-scale centred
    input  wire [`DUTY_BITS-1:0]     phaseA,
    input  wire [`DUTY_BITS-1:0]     phaseB,
    input  wire [`DUTY_BITS-1:0]     phaseC,
    // Inverter gates
    output reg  [2:0]                gateHigh_ff,
    output reg  [2:0]                gateLow_ff,
    output reg                       periodStart_ff
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Half of the carrier period; undefined codes fall back to the lowest rate
    function [`PER_BITS-1:0] halfPeriod;
        input [3:0]  code;
        integer      i;
        reg   [31:0] full;
        begin
            full = `PWM_PERIOD(0) / 2;
            for (i = 0; i < `FSW_CODES; i = i + 1) begin
                if (code == i) begin
                    full = `PWM_PERIOD(i) / 2;
                end
            end
            // Every defined half period fits the carrier counter
            halfPeriod = full[`PER_BITS-1:0];
        end
    endfunction

    // Scale a 12-bit duty to carrier counts
    function [`PER_BITS-1:0] scaleDuty;
        input [`DUTY_BITS-1:0] duty;
        input [`PER_BITS-1:0]  half;
        reg   [2*`PER_BITS-1:0] prod;
        begin
            prod      = duty * half;
            scaleDuty = prod[2*`PER_BITS-1:`DUTY_BITS];
        end
    endfunction

    // ----------------------------------------------------------------
    // Zero-sequence injection
    // ----------------------------------------------------------------
    reg [`DUTY_BITS-1:0] maxV;
    reg [`DUTY_BITS-1:0] minV;
    reg [`DUTY_BITS:0]   offs;
    reg [`DUTY_BITS-1:0] nxt_dA;
    reg [`DUTY_BITS-1:0] nxt_dB;
    reg [`DUTY_BITS-1:0] nxt_dC;

    // Continuous centres the envelope; discontinuous clamps the lowest phase
    always @* begin
        maxV = (phaseA > phaseB) ? phaseA : phaseB;
        maxV = (phaseC > maxV) ? phaseC : maxV;
        minV = (phaseA < phaseB) ? phaseA : phaseB;
        minV = (phaseC < minV) ? phaseC : minV;
        if (discontinuous) begin
            offs = {1'b0, minV};
        end else begin
            offs = (({1'b0, maxV} + {1'b0, minV}) >> 1) - `DUTY_MID;
        end
        nxt_dA = phaseA - offs[`DUTY_BITS-1:0];
        nxt_dB = phaseB - offs[`DUTY_BITS-1:0];
        nxt_dC = phaseC - offs[`DUTY_BITS-1:0];
    end

    // ----------------------------------------------------------------
    // Triangle carrier and compare
    // ----------------------------------------------------------------
    localparam [31:0]   HALF_RESET = `PWM_PERIOD(0) / 2;
    reg [`PER_BITS-1:0] cnt_ff;
    reg                 down_ff;
    reg [`PER_BITS-1:0] half_ff;
    reg [`PER_BITS-1:0] cmpA_ff;
    reg [`PER_BITS-1:0] cmpB_ff;
    reg [`PER_BITS-1:0] cmpC_ff;

    // Settings latch only at the valley, so a period is never torn
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_ff         <= {`PER_BITS{1'b0}};
            down_ff        <= 1'b0;
            half_ff        <= HALF_RESET[`PER_BITS-1:0];
            cmpA_ff        <= {`PER_BITS{1'b0}};
            cmpB_ff        <= {`PER_BITS{1'b0}};
            cmpC_ff        <= {`PER_BITS{1'b0}};
            gateHigh_ff    <= 3'b000;
            gateLow_ff     <= 3'b000;
            periodStart_ff <= 1'b0;
        end else if (ce) begin
            periodStart_ff <= 1'b0;
            if (!down_ff) begin
                if (cnt_ff >= half_ff - 1'b1) begin
                    down_ff <= 1'b1;
                end
                cnt_ff <= cnt_ff + 1'b1;
            end else if (cnt_ff == {`PER_BITS{1'b0}} + 1'b1) begin
                cnt_ff         <= {`PER_BITS{1'b0}};
                down_ff        <= 1'b0;
                periodStart_ff <= 1'b1;
                half_ff        <= halfPeriod(freqCode);
                cmpA_ff        <= scaleDuty(nxt_dA, halfPeriod(freqCode));
                cmpB_ff        <= scaleDuty(nxt_dB, halfPeriod(freqCode));
                cmpC_ff        <= scaleDuty(nxt_dC, halfPeriod(freqCode));
            end else begin
                cnt_ff <= cnt_ff - 1'b1;
            end
            gateHigh_ff <= {cmpC_ff > cnt_ff, cmpB_ff > cnt_ff, cmpA_ff > cnt_ff};
            gateLow_ff  <= {cmpC_ff <= cnt_ff, cmpB_ff <= cnt_ff, cmpA_ff <= cnt_ff};
        end
    end

endmodule
`default_nettype wire

// ### hw/closed_loop_ramp_pwm_config.v
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ramp_pwm_defs.vh"

module closed_loop_ramp_pwm_config (
    // Clock, reset, enable
    input  wire                      clk,
    input  wire                      sys_rst,
    input  wire                      ce,
    // APB slave
    input  wire                      psel,
    input  wire                      penable,
    input  wire                      pwrite,
    input  wire [`ADDR_BITS-1:0]     paddr,
    input  wire [31:0]               pwdata,
    output reg  [31:0]               prdata_ff,
    output reg                       pready_ff,
    output reg                       pslverr_ff,
    // Phase commands from the current loop
    input  wire [`DUTY_BITS-1:0]     phaseA,
    input  wire [`DUTY_BITS-1:0]     phaseB,
    input  wire [`DUTY_BITS-1:0]     phaseC,
    // Inverter gates and ramp output
    output wire [2:0]                gateHigh_ff,
    output wire [2:0]                gateLow_ff,
    output wire                      periodStart_ff,
    output reg  [`SPEED_BITS-1:0]    speedRef_ff,
    output reg                       deadbandCompEn_ff,
    output reg                       velocityLoopDis_ff
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Rate code to half-hertz per second
    function [17:0] rateOf;
        input [4:0] code;
        begin
            case (code)
                5'h00: rateOf = `RATE_00;
                5'h01: rateOf = `RATE_01;
                5'h02: rateOf = `RATE_02;
                5'h03: rateOf = `RATE_03;
                5'h04: rateOf = `RATE_04;
                5'h05: rateOf = `RATE_05;
                5'h06: rateOf = `RATE_06;
                5'h07: rateOf = `RATE_07;
                5'h08: rateOf = `RATE_08;
                5'h09: rateOf = `RATE_09;
                5'h0A: rateOf = `RATE_0A;
                5'h0B: rateOf = `RATE_0B;
                5'h0C: rateOf = `RATE_0C;
                5'h0D: rateOf = `RATE_0D;
                5'h0E: rateOf = `RATE_0E;
                5'h0F: rateOf = `RATE_0F;
                5'h10: rateOf = `RATE_10;
                5'h11: rateOf = `RATE_11;
                5'h12: rateOf = `RATE_12;
                5'h13: rateOf = `RATE_13;
                5'h14: rateOf = `RATE_14;
                5'h15: rateOf = `RATE_15;
                5'h16: rateOf = `RATE_16;
                5'h17: rateOf = `RATE_17;
                5'h18: rateOf = `RATE_18;
                5'h19: rateOf = `RATE_19;
                5'h1A: rateOf = `RATE_1A;
                5'h1B: rateOf = `RATE_1B;
                5'h1C: rateOf = `RATE_1C;
                5'h1D: rateOf = `RATE_1D;
                5'h1E: rateOf = `RATE_1E;
                default: rateOf = 18'h0_0000;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Registers and decode
    // ----------------------------------------------------------------
    reg  [31:0]             cfg_ff;
    reg  [`SPEED_BITS-1:0]  target_ff;
    reg  [4:0]              decelInUse_ff;
    wire [4:0]              accelCode = cfg_ff[`ACCEL_MSB:`ACCEL_LSB];
    wire [4:0]              decelCode = cfg_ff[`DECEL_MSB:`DECEL_LSB];
    wire [3:0]              freqRaw   = cfg_ff[`FSW_MSB:`FSW_LSB];
    wire [3:0]              freqCode;
    wire                    accessDone = psel & penable & pready_ff;
    wire                    hitCfg    = (paddr == `ADDR_CL_CONFIG_ONE);
    wire                    hitTarget = (paddr == `ADDR_TARGET_SPEED);
    wire                    hitStatus = (paddr == `ADDR_RAMP_STATUS);

    // Undefined frequency codes are replaced before the carrier sees them
    assign freqCode = (freqRaw > `FSW_LAST_CODE) ? `FSW_FALLBACK_CODE : freqRaw;

    // Decel code used only with surge guard off and source 0; else accel
    wire       useDecelCode = ~cfg_ff[`DECEL_SRC_BIT] & ~cfg_ff[`SURGE_EN_BIT];
    wire [4:0] nxt_decel    = useDecelCode ? decelCode : accelCode;

    // ----------------------------------------------------------------
    // APB slave: no wait state, answer registered
    // ----------------------------------------------------------------
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_ff     <= `CL_CONFIG_RESET;
            target_ff  <= {`SPEED_BITS{1'b0}};
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else if (ce) begin
            // Ready rises in the access phase, falls right after it
            pready_ff  <= psel & ~penable;
            pslverr_ff <= psel & ~penable & ~(hitCfg | hitTarget | hitStatus);
            if (psel & ~penable & ~pwrite) begin
                if (hitCfg) begin
                    prdata_ff <= cfg_ff;
                end else if (hitTarget) begin
                    prdata_ff <= {8'h00, target_ff};
                end else if (hitStatus) begin
                    prdata_ff <= {freqCode, 3'b000, decelInUse_ff, speedRef_ff[19:0]};
                end else begin
                    prdata_ff <= 32'h0000_0000;
                end
            end
            if (accessDone & pwrite & hitCfg) begin
                cfg_ff <= pwdata & `CL_CONFIG_MASK;
            end
            if (accessDone & pwrite & hitTarget) begin
                target_ff <= pwdata[`SPEED_BITS-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Speed reference ramp
    // ----------------------------------------------------------------
    reg  [31:0] frac_ff;
    wire        rising   = (target_ff > speedRef_ff);
    wire        falling  = (target_ff < speedRef_ff);
    wire [4:0]  nxt_code = rising ? accelCode : nxt_decel;
    wire [31:0] nxt_frac = frac_ff + {14'h0000, rateOf(nxt_code)};

    // Fractional accumulator: at most one half-hertz step per clock,
    // since the fastest rate is far below the clock rate
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            speedRef_ff   <= {`SPEED_BITS{1'b0}};
            frac_ff       <= 32'h0000_0000;
            decelInUse_ff <= 5'h00;
        end else if (ce) begin
            decelInUse_ff <= nxt_decel;
            if (!(rising | falling)) begin
                frac_ff <= 32'h0000_0000;
            end else if (nxt_code == `RATE_NO_LIMIT_CODE) begin
                speedRef_ff <= target_ff;
                frac_ff     <= 32'h0000_0000;
            end else if (nxt_frac >= `RATE_CYCLES_PER_S) begin
                frac_ff <= nxt_frac - `RATE_CYCLES_PER_S;
                if (rising) begin
                    speedRef_ff <= speedRef_ff + 1'b1;
                end else begin
                    speedRef_ff <= speedRef_ff - 1'b1;
                end
            end else begin
                frac_ff <= nxt_frac;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pass-through enables, registered
    // ----------------------------------------------------------------
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            deadbandCompEn_ff  <= 1'b0;
            velocityLoopDis_ff <= 1'b0;
        end else if (ce) begin
            deadbandCompEn_ff  <= cfg_ff[`DEADBAND_EN_BIT];
            velocityLoopDis_ff <= cfg_ff[`VLOOP_DIS_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Carrier and modulator
    // ----------------------------------------------------------------
    svm_pwm_gen pwmGen (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .ce             (ce),
        .freqCode       (freqCode),
        .discontinuous  (cfg_ff[`PWM_MODE_BIT]),
        .phaseA         (phaseA),
        .phaseB         (phaseB),
        .phaseC         (phaseC),
        .gateHigh_ff    (gateHigh_ff),
        .gateLow_ff     (gateLow_ff),
        .periodStart_ff (periodStart_ff)
    );

endmodule
`default_nettype wire

// ### verif/ramp_pwm_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ramp_pwm_checker (
    // Clock, reset, enable
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        ce,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata_ff,
    input wire logic        pready_ff,
    input wire logic        pslverr_ff,
    // Gates and ramp
    input wire logic [2:0]  gateHigh_ff,
    input wire logic [2:0]  gateLow_ff,
    input wire logic        periodStart_ff,
    input wire logic [23:0] speedRef_ff,
    input wire logic        deadbandCompEn_ff,
    input wire logic        velocityLoopDis_ff
);
    // ----------------------------------------------------------------
    // Shadow of the configuration word
    // ----------------------------------------------------------------
    wire wrCfg = psel & penable & pready_ff & pwrite & ce & (paddr == 12'h048);
    wire unmapped = (paddr != 12'h048) && (paddr != 12'h080) && (paddr != 12'h084);
    logic [31:0] cfgShadow_ff;
    // Shadow lets ramp checks know which rate codes are live
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) cfgShadow_ff <= 32'h0000_0000;
        else if (wrCfg) cfgShadow_ff <= pwdata;
    end
    wire noJump = (cfgShadow_ff[18:14] != 5'h1F) && (cfgShadow_ff[12:8] != 5'h1F);

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_ready_setup: assert property (psel && !penable && ce |=> pready_ff)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready_ff |=> !pready_ff)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (pready_ff |-> pslverr_ff == unmapped)
        else $error("error response wrong");
    a_read_cfg: assert property (psel && !penable && !pwrite && ce && paddr == 12'h048
        |=> prdata_ff == cfgShadow_ff) else $error("config read data wrong");
    a_copy_bits: assert property (wrCfg ##1 ce
        |=> {deadbandCompEn_ff, velocityLoopDis_ff} == $past(pwdata[2:1], 2))
        else $error("config copies wrong");
    a_start_pulse: assert property (periodStart_ff |=> !periodStart_ff)
        else $error("period start too long");
    a_gates_compl: assert property (periodStart_ff |=> gateLow_ff == ~gateHigh_ff)
        else $error("gates not complementary");
    a_ramp_step: assert property (noJump |=> speedRef_ff == $past(speedRef_ff)
        || speedRef_ff == $past(speedRef_ff) + 24'h00_0001
        || speedRef_ff == $past(speedRef_ff) - 24'h00_0001) else $error("ramp jumped");
    // Enable low must hold ramp, high-side gates and bus answer where they stand
    a_ce_freeze: assert property (!ce |=> $stable(speedRef_ff) && $stable(gateHigh_ff)
        && $stable(pready_ff)) else $error("state moved with enable low");

    c_unmapped: cover property (pready_ff && pslverr_ff);
    c_jump: cover property (cfgShadow_ff[18:14] == 5'h1F && $changed(speedRef_ff));
    c_start: cover property (periodStart_ff ##1 !periodStart_ff);
endmodule

bind closed_loop_ramp_pwm_config ramp_pwm_checker u_chk (.clk, .sys_rst, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata_ff, .pready_ff, .pslverr_ff, .gateHigh_ff,
    .gateLow_ff, .periodStart_ff, .speedRef_ff, .deadbandCompEn_ff, .velocityLoopDis_ff);
`default_nettype wire

// ### verif/inverter_model.sv
`timescale 1ns/100ps
`default_nettype none
module inverter_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Gates from the block
    input  wire logic [2:0]  gateHigh_ff,
    input  wire logic [2:0]  gateLow_ff,
    input  wire logic        periodStart_ff,
    // Per-period measurements
    output logic [15:0]      periodLen,
    output logic [2:0][15:0] onCnt,
    output logic             shootThrough
);
    logic [15:0]      cnt;
    logic [2:0][15:0] acc;
    // Both switches of a leg on would short the bus, so it is latched
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 16'h0000;
            acc <= '0;
            periodLen <= 16'h0000;
            onCnt <= '0;
            shootThrough <= 1'b0;
        end else begin
            if (|(gateHigh_ff & gateLow_ff)) shootThrough <= 1'b1;
            cnt <= periodStart_ff ? 16'h0001 : cnt + 16'h0001;
            if (periodStart_ff) periodLen <= cnt;
            if (periodStart_ff) onCnt <= acc;
            for (int i = 0; i < 3; i++)
                acc[i] <= periodStart_ff ? 16'(gateHigh_ff[i]) : acc[i] + 16'(gateHigh_ff[i]);
        end
    end
endmodule
`default_nettype wire

// ### verif/closed_loop_ramp_pwm_config_bench.sv
`timescale 1ns/100ps
`default_nettype none
module closed_loop_ramp_pwm_config_bench;
    logic             clk = 1'b0;
    logic             sys_rst, ce, psel, penable, pwrite, pready_ff, pslverr_ff, err;
    logic [11:0]      paddr, phaseA, phaseB, phaseC;
    logic [31:0]      pwdata, prdata_ff, rd;
    logic [2:0]       gateHigh_ff, gateLow_ff;
    logic             periodStart_ff, deadbandCompEn_ff, velocityLoopDis_ff, shootThrough;
    logic [23:0]      speedRef_ff;
    logic [15:0]      periodLen;
    logic [2:0][15:0] onCnt;
    int               fail_count = 0, comparisons = 0, cyc = 0;
    // Ramp cases: config, start, target, value after 4 and after 200 cycles
    logic [31:0]      rampCfg [5] = '{32'h0007_9F00, 32'h0007_BF00, 32'h0007_9F08,
                                      32'h0007_DE00, 32'h0007_9E00};
    int               rampV [5][4] = '{'{10, 0, 0, 0}, '{10, 0, 10, 9}, '{10, 0, 10, 9},
                                       '{10, 0, 10, 9}, '{0, 10, 0, 1}};

    always #20 clk = ~clk;

    closed_loop_ramp_pwm_config u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
        .phaseA(phaseA), .phaseB(phaseB), .phaseC(phaseC), .gateHigh_ff(gateHigh_ff),
        .gateLow_ff(gateLow_ff), .periodStart_ff(periodStart_ff), .speedRef_ff(speedRef_ff),
        .deadbandCompEn_ff(deadbandCompEn_ff), .velocityLoopDis_ff(velocityLoopDis_ff));
    inverter_model u_inv (.clk(clk), .sys_rst(sys_rst), .gateHigh_ff(gateHigh_ff),
        .gateLow_ff(gateLow_ff), .periodStart_ff(periodStart_ff), .periodLen(periodLen),
        .onCnt(onCnt), .shootThrough(shootThrough));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Idle edge at the end keeps psel from falling and rising in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No timeout here; only the hang guard ends this wait if ready never comes
        do @(posedge clk); while (pready_ff !== 1'b1);
        rd = prdata_ff;
        err = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic waitStart;
        int n;
        n = 0;
        do begin @(posedge clk); n++; end while (periodStart_ff !== 1'b1 && n < 3000);
    endtask
    task automatic print_verdict;
        $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard, well above the roughly 55k cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            fail_count++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        sys_rst <= 1'b1;
        ce <= 1'b1;
        {psel, penable, pwrite, paddr, pwdata} <= '0;
        phaseA <= 12'h900;
        phaseB <= 12'h800;
        phaseC <= 12'h700;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        apb(0, 12'h048, 0);
        chk(rd, 32'h0000_0000);
        apb(1, 12'h048, 32'hA5A5_A5A6);
        apb(0, 12'h048, 0);
        chk(rd, 32'hA5A5_A5A6);
        chk({deadbandCompEn_ff, velocityLoopDis_ff}, 2'b11);
        apb(1, 12'h100, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        apb(0, 12'h100, 0);
        chk(rd, 32'h0000_0000);
        chk(err, 1'b1);
        apb(1, 12'h084, 0);
        chk(err, 1'b0);
        $display("test registers done");
        // Every code, the two undefined ones included
        for (int c = 0; c < 16; c++) begin
            apb(1, 12'h048, 32'(c) << 4);
            repeat (3) waitStart();
            @(posedge clk);
            chk(periodLen, c > 13 ? 2500 : 2 * ((25000000 / (10000 + 5000 * c)) / 2));
            apb(0, 12'h084, 0);
            chk(rd[31:28], c > 13 ? 0 : c);
        end
        $display("test switching frequency done");
        // Lowest phase must sit clamped low only when discontinuous
        for (int m = 0; m < 2; m++) begin
            apb(1, 12'h048, 32'h0000_00D0 | m);
            repeat (3) waitStart();
            @(posedge clk);
            chk(onCnt[2] == 16'h0000, m);
            chk(onCnt[0] == 16'h0000, 0);
        end
        $display("test modulation done");
        for (int i = 0; i < 5; i++) begin
            apb(1, 12'h048, 32'h0007_DF00);
            apb(1, 12'h080, rampV[i][0]);
            repeat (4) @(posedge clk);
            chk(speedRef_ff, rampV[i][0]);
            apb(1, 12'h048, rampCfg[i]);
            apb(1, 12'h080, rampV[i][1]);
            repeat (4) @(posedge clk);
            chk(speedRef_ff, rampV[i][2]);
            repeat (196) @(posedge clk);
            chk(speedRef_ff, rampV[i][3]);
        end
        chk(shootThrough, 1'b0);
        $display("test ramp done");
        // Slow ramp 0 to 10 is at 1; without the freeze it would reach 2
        ce <= 1'b0;
        repeat (300) @(posedge clk);
        chk(speedRef_ff, 1);
        ce <= 1'b1;
        repeat (200) @(posedge clk);
        chk(speedRef_ff, 2);
        $display("test clock enable done");
        print_verdict();
    end
endmodule
`default_nettype wire
